// >>> bus_ctl.sv
// behavioural i2c bus controller facing the target port
`timescale 1ns/1ps
`default_nettype none
module bus_ctl (
    // bus lines, released means pulled up
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    // ********************
    // bit, byte and framing tasks
    // ********************
    int half = 1250;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic bit_io(input logic b, output logic r);
        #(half / 2) sda_rel = b;
        #(half / 2) scl = 1'b1;
        #(half / 2) r = sda;
        #(half / 2) scl = 1'b0;
    endtask
    task automatic start();
        sda_rel = 1'b1;
        #(half) scl = 1'b1;
        #(half) sda_rel = 1'b0;
        #(half) scl = 1'b0;
    endtask
    task automatic stop();
        #(half / 2) sda_rel = 1'b0;
        #(half / 2) scl = 1'b1;
        #(half) sda_rel = 1'b1;
        #(half);
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(output logic [7:0] b, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(nack, r);
    endtask
endmodule // bus_ctl
`default_nettype wire

// >>> charger_host_i2c_thermal_monitor.sv
// i2c target, thermistor monitor and supply-good output
// Function
// [R1] supply-good pin shows input supply, host bit, or manual reset copy
// [R2] bias thermistor only while sampling, 25 ms of each 225 ms
// [R3] bias-off request ignored while input supply present
// [R4] thermistor control: full profile, hot/cold only, or disabled
// [R5] hot or cold zone suspends charging and safety timer
// [R6] cool zone scales charge current by programmed fraction, 111 is 1/8
// [R7] derated current truncated down to whole current steps
// [R8] warm zone lowers regulation voltage to programmed value
// [R9] any zone fault pulses interrupt 128 us and sets fault bits
// [R10] fault bits stay set until host reads them
// [R11] thermistor voltage readable when supply or battery present
// [R12] interrupt on every threshold crossing; thresholds host adjustable
// [R13] charging disabled above open-sensor threshold
// [R14] target only, standard and fast mode
// [R15] fixed target address 0x6B
// [R16] start condition detected anywhere
// [R17] address byte; sda sampled on scl high, changed on scl low
// [R18] acknowledge matching address through ninth clock high
// [R19] bytes of nine bits, receiver acknowledges, unlimited count
// [R20] stop returns target to idle
// [R21] stop after abort resets target state machine
// [R22] unlisted register reads all ones
// [R23] direction bit zero is write, one is read
`timescale 1ns/1ps
`default_nettype none
module charger_host_i2c_thermal_monitor
    import charger_host_pkg::*;
#(
    parameter int BIAS_CYC   = TS_BIAS_CYC,
    parameter int PERIOD_CYC = TS_PERIOD_CYC,
    parameter int INT_CYC    = INT_PULSE_CYC
) (
    // system clock and control
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // i2c link
    input  wire logic       link_clk,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    // supply and button pins
    input  wire logic       input_supply_good,
    input  wire logic       bat_present,
    input  wire logic       manual_reset_input_n,
    // thermistor front end
    input  wire logic [7:0] ts_sample,
    input  wire logic       ts_sample_valid,
    output logic            thermistor_sense_pin_bias,
    // charger core
    input  wire logic [7:0] fast_charge_current,
    output logic [7:0]      charge_current_code,
    output logic [1:0]      vreg_drop_code,
    output logic            charge_suspend,
    output logic            safety_timer_pause,
    // host signalling
    output logic            int_n,
    output logic            supply_good_output_o,
    output logic            supply_good_output_oe_n
);
    // ********************
    // declarations
    // ********************
    logic [2:0]  pin_s1, pin_s2, pin_s3, pin_f;
    logic        vin_ok, bat_ok, mr_n;
    logic        lrst_s1, link_rstn;
    logic [1:0]  ln_s1, ln_s2, ln_s3, ln_f, lp;
    logic        scl, sda, scl_rise, scl_fall, start_c, stop_c;
    i2c_state_t  state;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg, tx, ptr, wr_addr, wr_data, cm_addr, rd_buf;
    logic        rw, first;
    logic        wr_tog, pf_tog, cm_tog, ra_tog;
    logic [2:0]  ra_s, xs1, xs2, xs3, ev;
    logic [7:0]  rd_data, rd_mux, fault_clr;
    logic [7:0]  ctrl, tca, fault, snap, ts_volt;
    logic [7:0]  thr [5];
    logic [4:0]  zone, next_zone, rise;
    logic        mon_on, hold;
    logic [23:0] cnt;
    logic [15:0] int_cnt, next_int_cnt;
    logic [11:0] derate;
    ts_mode_t    mode;
    pg_mode_t    pg_mode;

    assign vin_ok  = pin_f[0];
    assign bat_ok  = pin_f[1];
    assign mr_n    = pin_f[2];
    assign scl     = ln_f[1];
    assign sda     = ln_f[0];
    assign mode    = ts_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
    assign pg_mode = pg_mode_t'(ctrl[CTRL_PG_LSB +: 2]);

    // ********************
    // pin synchronisers, system clock
    // ********************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_s1 <= PIN_RST;
            pin_s2 <= PIN_RST;
            pin_s3 <= PIN_RST;
            pin_f  <= PIN_RST;
        end else if (ce) begin
            pin_s1 <= {manual_reset_input_n, bat_present, input_supply_good};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f  <= (pin_s2 & ~(pin_s2 ^ pin_s3))
                    | (pin_f & (pin_s2 ^ pin_s3));
        end
    end

    // ********************
    // link domain: reset, pin sync, condition detect
    // ********************
    always_ff @(posedge link_clk) begin
        lrst_s1   <= rstn;
        link_rstn <= lrst_s1;
    end
    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            ln_s1 <= 2'h3;
            ln_s2 <= 2'h3;
            ln_s3 <= 2'h3;
            ln_f  <= 2'h3;
            lp    <= 2'h3;
        end else begin
            ln_s1 <= {scl_i, sda_i}; // see R14
            ln_s2 <= ln_s1;
            ln_s3 <= ln_s2;
            ln_f  <= (ln_s2 & ~(ln_s2 ^ ln_s3)) | (ln_f & (ln_s2 ^ ln_s3));
            lp    <= ln_f;
        end
    end
    assign scl_rise = scl & ~lp[1];
    assign scl_fall = ~scl & lp[1];
    assign start_c  = scl & lp[1] & lp[0] & ~sda; // see R16
    assign stop_c   = scl & lp[1] & ~lp[0] & sda; // see R20

    // ********************
    // link domain: target state machine
    // ********************
    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            state    <= S_IDLE;
            bitcnt   <= 4'h0;
            ptr      <= 8'h00;
            rw       <= 1'b0;
            first    <= 1'b0;
            wr_tog   <= 1'b0;
            pf_tog   <= 1'b0;
            cm_tog   <= 1'b0;
            sda_oe_n <= 1'b1;
            sda_o    <= 1'b0;
        end else if (start_c || stop_c) begin
            state    <= start_c ? S_ADDR : S_IDLE; // see R16 see R20 see R21
            bitcnt   <= 4'h0;
            sda_oe_n <= 1'b1;
        end else if (scl_rise) begin
            case (state)
                S_ADDR, S_WR: begin
                    shreg  <= {shreg[6:0], sda}; // see R17
                    bitcnt <= bitcnt + 4'h1;
                end
                S_RD: bitcnt <= bitcnt + 4'h1;
                S_RACK: if (sda) state <= S_IDLE; // nack ends read
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state)
                S_ADDR: begin
                    if (bitcnt == 4'h8) begin
                        if (shreg[7:1] == TARGET_ADDR) begin // see R15
                            sda_oe_n <= 1'b0; // see R18
                            rw       <= shreg[0]; // see R23
                            state    <= S_AACK;
                        end else begin
                            state <= S_IDLE; // see R18
                        end
                    end
                end
                S_AACK, S_RACK: begin
                    bitcnt <= 4'h0;
                    first  <= 1'b1;
                    if (state == S_AACK && !rw) begin
                        sda_oe_n <= 1'b1;
                        state    <= S_WR;
                    end else begin
                        // present prefetched byte, fetch next
                        sda_oe_n <= rd_buf[7]; // see R19
                        tx       <= {rd_buf[6:0], 1'b0};
                        state    <= S_RD;
                        cm_addr  <= ptr;
                        cm_tog   <= ~cm_tog;
                        ptr      <= ptr + 8'h01;
                        pf_tog   <= ~pf_tog;
                    end
                end
                S_WR: begin
                    if (bitcnt == 4'h8) begin
                        sda_oe_n <= 1'b0; // see R19
                        state    <= S_WACK;
                        first    <= 1'b0;
                        pf_tog   <= ~pf_tog;
                        if (first) begin
                            ptr <= shreg;
                        end else begin
                            wr_addr <= ptr;
                            wr_data <= shreg;
                            wr_tog  <= ~wr_tog;
                            ptr     <= ptr + 8'h01;
                        end
                    end
                end
                S_WACK: begin
                    sda_oe_n <= 1'b1;
                    bitcnt   <= 4'h0;
                    state    <= S_WR;
                end
                S_RD: begin
                    if (bitcnt == 4'h8) begin
                        sda_oe_n <= 1'b1; // controller acknowledges
                        state    <= S_RACK;
                    end else begin
                        sda_oe_n <= tx[7]; // see R17
                        tx       <= {tx[6:0], 1'b0};
                    end
                end
                default: ;
            endcase
        end
    end

    // read answer captured when its toggle arrives
    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            ra_s   <= 3'h0;
            rd_buf <= UNMAPPED;
        end else begin
            ra_s <= {ra_s[1:0], ra_tog};
            if (ra_s[1] ^ ra_s[2]) rd_buf <= rd_data;
        end
    end

    // ********************
    // system domain: request crossing and register file
    // ********************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            xs1 <= 3'h0;
            xs2 <= 3'h0;
            xs3 <= 3'h0;
        end else if (ce) begin
            xs1 <= {cm_tog, pf_tog, wr_tog};
            xs2 <= xs1;
            xs3 <= xs2;
        end
    end
    assign ev = xs2 ^ xs3;
    always_comb begin
        rd_mux = UNMAPPED; // see R22
        if (ptr >= REG_THR0 && ptr <= REG_THRN) begin
            rd_mux = thr[3'(ptr - REG_THR0)];
        end else begin
            case (ptr)
                REG_STATUS: rd_mux = {1'b0, bat_ok, vin_ok, zone};
                REG_FAULT:  rd_mux = fault;
                REG_TSV:    rd_mux = (vin_ok | bat_ok) ? ts_volt : 8'h00;
                REG_CTRL:   rd_mux = ctrl;
                REG_TCA:    rd_mux = tca;
                default:    rd_mux = UNMAPPED; // see R22
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl   <= CTRL_RST;
            tca    <= TCA_RST;
            thr[Z_HOT]  <= mv_to_code(TS_HOT_MV);
            thr[Z_WARM] <= mv_to_code(TS_WARM_MV);
            thr[Z_COOL] <= mv_to_code(TS_COOL_MV);
            thr[Z_COLD] <= mv_to_code(TS_COLD_MV);
            thr[Z_OPEN] <= mv_to_code(TS_OPEN_MV);
        end else if (ce && ev[0]) begin
            if (wr_addr >= REG_THR0 && wr_addr <= REG_THRN) begin
                thr[3'(wr_addr - REG_THR0)] <= wr_data; // see R12
            end else if (wr_addr == REG_CTRL) begin
                ctrl <= wr_data; // see R4
            end else if (wr_addr == REG_TCA) begin
                tca <= wr_data;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data <= UNMAPPED;
            ra_tog  <= 1'b0;
            snap    <= 8'h00;
        end else if (ce && ev[1]) begin
            rd_data <= rd_mux;
            ra_tog  <= ~ra_tog;
            snap    <= (ptr == REG_FAULT) ? fault : 8'h00;
        end
    end

    // ********************
    // thermistor sampling and zones
    // ********************
    assign mon_on = vin_ok | (bat_ok & ctrl[CTRL_BIAS_BIT]); // see R3
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt     <= 24'h000000;
            ts_volt <= TS_VOLT_RST;
            thermistor_sense_pin_bias <= 1'b0;
        end else if (ce) begin
            if (!mon_on || cnt == 24'(PERIOD_CYC - 1)) begin
                cnt <= 24'h000000;
            end else begin
                cnt <= cnt + 24'h000001;
            end
            thermistor_sense_pin_bias <= mon_on && cnt < 24'(BIAS_CYC); // see R2
            if (thermistor_sense_pin_bias && ts_sample_valid) begin
                ts_volt <= ts_sample; // see R11
            end
        end
    end
    always_comb begin
        next_zone         = 5'h00;
        next_zone[Z_OPEN] = ts_volt > thr[Z_OPEN]; // see R13
        next_zone[Z_COLD] = !next_zone[Z_OPEN] && ts_volt > thr[Z_COLD];
        next_zone[Z_COOL] = ts_volt > thr[Z_COOL] && ts_volt <= thr[Z_COLD];
        next_zone[Z_WARM] = ts_volt < thr[Z_WARM] && ts_volt >= thr[Z_HOT];
        next_zone[Z_HOT]  = ts_volt < thr[Z_HOT];
    end
    assign rise      = next_zone & ~zone;
    assign fault_clr = (ev[2] && cm_addr == REG_FAULT) ? snap : 8'h00;
    always_comb begin
        next_int_cnt = int_cnt;
        if (next_zone != zone) begin
            next_int_cnt = 16'(INT_CYC); // see R9 see R12
        end else if (int_cnt != 16'h0000) begin
            next_int_cnt = int_cnt - 16'h0001;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            zone    <= 5'h00;
            fault   <= 8'h00;
            int_cnt <= 16'h0000;
            int_n   <= 1'b1;
        end else if (ce) begin
            zone    <= next_zone;
            // set wins over clear-on-read
            fault   <= (fault & ~fault_clr) | {3'h0, rise}; // see R9 see R10
            int_cnt <= next_int_cnt;
            int_n   <= next_int_cnt == 16'h0000; // see R9
        end
    end

    // ********************
    // charge control and supply-good pin
    // ********************
    assign derate = 12'(fast_charge_current
                  * (SCALE_FULL - {1'b0, tca[TCA_SCALE_LSB +: 3]}));
    assign hold = zone[Z_OPEN] | (mode inside {TS_FULL, TS_HOTCOLD}
                  && (zone[Z_HOT] || zone[Z_COLD])); // see R5 see R13
    always_ff @(posedge clk) begin
        if (!rstn) begin
            charge_suspend      <= 1'b0;
            safety_timer_pause  <= 1'b0;
            charge_current_code <= 8'h00;
            vreg_drop_code      <= 2'h0;
        end else if (ce) begin
            charge_suspend     <= hold; // see R5 see R13
            safety_timer_pause <= hold; // see R5
            charge_current_code <= (mode == TS_FULL && zone[Z_COOL])
                ? derate[10:3] : fast_charge_current; // see R6 see R7
            vreg_drop_code <= (mode == TS_FULL && zone[Z_WARM])
                ? tca[TCA_VREG_LSB +: 2] : 2'h0; // see R8
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            supply_good_output_o    <= 1'b0;
            supply_good_output_oe_n <= 1'b1;
        end else if (ce) begin
            supply_good_output_o <= 1'b0;
            case (pg_mode)
                PG_HOST:   supply_good_output_oe_n <= ctrl[CTRL_HOST_BIT];
                PG_MANUAL: supply_good_output_oe_n <= mr_n; // see R1
                default:   supply_good_output_oe_n <= !vin_ok; // see R1
            endcase
        end
    end
endmodule // charger_host_i2c_thermal_monitor
`default_nettype wire

// >>> charger_host_i2c_thermal_monitor_sva.sv
// timing checker for the charger host block
`timescale 1ns/1ps
`default_nettype none
module charger_host_i2c_thermal_monitor_sva #(
    parameter int BIAS_CYC   = 20,
    parameter int PERIOD_CYC = 100,
    parameter int INT_CYC    = 16
) (
    // clocks and reset
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       link_clk,
    // watched pins
    input wire logic       scl_i,
    input wire logic       sda_oe_n,
    input wire logic       input_supply_good,
    input wire logic       thermistor_sense_pin_bias,
    input wire logic [7:0] fast_charge_current,
    input wire logic [7:0] charge_current_code,
    input wire logic       charge_suspend,
    input wire logic       safety_timer_pause,
    input wire logic       int_n
);
    // ********************
    // run-length counters
    // ********************
    int on_cnt;
    int off_cnt;
    int low_cnt;
    wire logic bias = thermistor_sense_pin_bias;
    always_ff @(posedge clk)
        on_cnt <= (!rstn || !bias) ? 0 : on_cnt + 1;
    always_ff @(posedge clk)
        off_cnt <= (!rstn || bias || !input_supply_good) ? 0 : off_cnt + 1;
    always_ff @(posedge clk)
        low_cnt <= (!rstn || int_n) ? 0 : low_cnt + 1;

    property p_bias_len;
        @(posedge clk) disable iff (!rstn) on_cnt <= BIAS_CYC;
    endproperty
    a_bias_len: assert property (p_bias_len)
        else $error("bias window too long");
    property p_bias_gap;
        @(posedge clk) disable iff (!rstn) off_cnt <= PERIOD_CYC + 8;
    endproperty
    a_bias_gap: assert property (p_bias_gap)
        else $error("bias missing while supply present");
    property p_int_hold;
        @(posedge clk) disable iff (!rstn) $fell(int_n) |-> !int_n [*8];
    endproperty
    a_int_hold: assert property (p_int_hold)
        else $error("interrupt pulse cut short");
    property p_int_len;
        @(posedge clk) disable iff (!rstn) $rose(int_n) |-> low_cnt >= INT_CYC;
    endproperty
    a_int_len: assert property (p_int_len)
        else $error("interrupt pulse too short");
    property p_sda_stable;
        @(posedge link_clk) disable iff (!rstn)
            scl_i && $past(scl_i) |-> $stable(sda_oe_n);
    endproperty
    a_sda_stable: assert property (p_sda_stable)
        else $error("sda changed while scl high");
    property p_susp_pair;
        @(posedge clk) disable iff (!rstn)
            charge_suspend == safety_timer_pause;
    endproperty
    a_susp_pair: assert property (p_susp_pair)
        else $error("suspend and timer pause differ");
    property p_susp_int;
        @(posedge clk) disable iff (!rstn)
            $rose(charge_suspend) |-> ##[0:3] !int_n;
    endproperty
    a_susp_int: assert property (p_susp_int)
        else $error("zone change without interrupt");
    property p_cur_floor;
        @(posedge clk) disable iff (!rstn)
            charge_current_code <= fast_charge_current;
    endproperty
    a_cur_floor: assert property (p_cur_floor)
        else $error("charge current above programmed value");
    c_bias: cover property (@(posedge clk) $rose(bias));
    c_int: cover property (@(posedge clk) $fell(int_n));
    c_ack: cover property (@(posedge link_clk) $fell(sda_oe_n));
endmodule // charger_host_i2c_thermal_monitor_sva
bind charger_host_i2c_thermal_monitor charger_host_i2c_thermal_monitor_sva #(
    .BIAS_CYC(BIAS_CYC), .PERIOD_CYC(PERIOD_CYC), .INT_CYC(INT_CYC)
) sva_inst (
    .clk, .rstn, .link_clk, .scl_i, .sda_oe_n, .input_supply_good,
    .thermistor_sense_pin_bias, .fast_charge_current,
    .charge_current_code, .charge_suspend, .safety_timer_pause, .int_n);
`default_nettype wire

// >>> charger_host_i2c_thermal_monitor_test.sv
// self-checking bench for the charger host block
`timescale 1ns/1ps
`default_nettype none
module charger_host_i2c_thermal_monitor_test
    import charger_host_pkg::*;
;
    typedef struct { logic [7:0] p; logic [7:0] e; } row_t;
    logic       clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       input_supply_voltage = 1'b1;
    logic       btn_n = 1'b1;
    logic       bat = 1'b1;
    logic [7:0] ts = 8'h50;
    logic [7:0] cur = 8'h0C;
    logic       scl, sda_rel, sda_o, sda_oe_n, bias, susp, pause, int_n;
    logic       pg_o, pg_oe_n, ack, hit;
    logic [7:0] cur_code, rd;
    logic [1:0] vreg;
    int         error_cnt = 0;
    int         total_checks = 0;
    wire logic  sda = sda_rel & (sda_oe_n | sda_o);
    row_t       rows [6] = '{'{8'h03, 8'h24}, '{8'h04, 8'h00},
        '{8'h06, 8'h38}, '{8'h08, 8'h7C}, '{8'h09, 8'hC0}, '{8'h0A, 8'hFF}};
    logic [9:0] pg_rows [4] = '{{8'h28, 2'b11}, {8'h08, 2'b10},
        {8'h10, 2'b00}, {8'h10, 2'b11}};

    always #12.5 clk = ~clk;
    initial #7 forever #32 link_clk = ~link_clk;

    charger_host_i2c_thermal_monitor #(
        .BIAS_CYC(20), .PERIOD_CYC(100), .INT_CYC(16)
    ) charger_host_i2c_thermal_monitor_inst (
        .clk, .rstn, .ce(1'b1), .link_clk,
        .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_n,
        .input_supply_good(input_supply_voltage), .bat_present(bat),
        .manual_reset_input_n(btn_n), .ts_sample(ts), .ts_sample_valid(1'b1),
        .thermistor_sense_pin_bias(bias), .fast_charge_current(cur),
        .charge_current_code(cur_code), .vreg_drop_code(vreg),
        .charge_suspend(susp), .safety_timer_pause(pause), .int_n,
        .supply_good_output_o(pg_o), .supply_good_output_oe_n(pg_oe_n));
    bus_ctl bus_ctl_inst (.scl(scl), .sda_rel(sda_rel), .sda(sda));

    // ********************
    // shared tasks
    // ********************
    task automatic check(input string n, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic point(input logic [7:0] p);
        bus_ctl_inst.start();
        bus_ctl_inst.send(8'hD6, ack);
        check("address ack", {7'h0, ack}, 8'h01);
        bus_ctl_inst.send(p, ack);
    endtask
    task automatic reg_wr(input logic [7:0] p, d);
        point(p);
        bus_ctl_inst.send(d, ack);
        check("data ack", {7'h0, ack}, 8'h01);
        bus_ctl_inst.stop();
    endtask
    task automatic rd_chk(input string n, input logic [7:0] p, e);
        point(p);
        bus_ctl_inst.stop();
        bus_ctl_inst.start();
        bus_ctl_inst.send(8'hD7, ack);
        bus_ctl_inst.recv(rd, 1'b1);
        bus_ctl_inst.stop();
        check(n, rd, e);
    endtask
    task automatic settle(input logic [7:0] v);
        @(posedge clk) ts <= v;
        repeat (300) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #2_800_000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge link_clk);
        @(posedge clk);
        check("int idle", {7'h0, int_n}, 8'h01);
        check("pg in reset", {7'h0, pg_oe_n}, 8'h01);
        rstn <= 1'b1;
        repeat (20) @(posedge clk);
        check("pg supply", {7'h0, pg_oe_n}, 8'h00);
        foreach (rows[i]) rd_chk("reset", rows[i].p, rows[i].e);
        reg_wr(REG_TCA, 8'h27);
        settle(8'h74);
        check("cool current", cur_code, 8'h01);
        rd_chk("cool fault", REG_FAULT, 8'h04);
        rd_chk("fault clear", REG_FAULT, 8'h00);
        rd_chk("ts voltage", REG_TSV, 8'h74);
        settle(8'h30);
        check("warm vreg", {6'h0, vreg}, 8'h02);
        check("warm current", cur_code, 8'h0C);
        settle(8'h10);
        check("hot suspend", {7'h0, susp}, 8'h01);
        rd_chk("hot status", REG_STATUS, 8'h61);
        settle(8'hD0);
        check("open suspend", {7'h0, susp}, 8'h01);
        settle(8'h50);
        check("normal run", {7'h0, susp}, 8'h00);
        reg_wr(REG_CTRL, 8'h25);
        settle(8'h74);
        check("hot-cold derate", cur_code, 8'h0C);
        settle(8'h10);
        check("hot-cold hot", {7'h0, susp}, 8'h01);
        reg_wr(REG_CTRL, 8'h26);
        check("disabled", {7'h0, susp}, 8'h00);
        settle(8'h50);
        reg_wr(REG_CTRL, 8'h20);
        hit = 1'b0;
        repeat (300) @(posedge clk) hit |= bias;
        check("bias kept", {7'h0, hit}, 8'h01);
        foreach (pg_rows[i]) begin
            @(posedge clk) btn_n <= pg_rows[i][1];
            reg_wr(REG_CTRL, pg_rows[i][9:2]);
            repeat (20) @(posedge clk);
            check("pg pin", {6'h0, pg_o, pg_oe_n}, {7'h0, pg_rows[i][0]});
        end
        bus_ctl_inst.start();
        bus_ctl_inst.send(8'hD4, ack);
        check("foreign address", {7'h0, ack}, 8'h00);
        bus_ctl_inst.stop();
        point(REG_THR0);
        bus_ctl_inst.stop();
        @(posedge clk) input_supply_voltage <= 1'b0;
        bat <= 1'b0;
        rd_chk("ts unpowered", REG_TSV, 8'h00);
        bus_ctl_inst.half = 5000;
        rd_chk("slow read", REG_THR0, 8'h27);
        wrap_up();
    end
endmodule // charger_host_i2c_thermal_monitor_test
`default_nettype wire

// >>> charger_host_pkg.sv
// constants, register map and types for the charger host logic
`default_nettype none
package charger_host_pkg;
    // ********************
    // clock and timing
    // ********************
    localparam int CLK_HZ        = 40_000_000;
    localparam int TS_BIAS_MS    = 25;
    localparam int TS_PERIOD_MS  = 225;
    localparam int INT_PULSE_US  = 128;
    localparam int TS_BIAS_CYC   = TS_BIAS_MS * (CLK_HZ / 1000);
    localparam int TS_PERIOD_CYC = TS_PERIOD_MS * (CLK_HZ / 1000);
    localparam int INT_PULSE_CYC = INT_PULSE_US * (CLK_HZ / 1000000);

    // ********************
    // bus target address and register offsets
    // ********************
    localparam logic [6:0] TARGET_ADDR = 7'h6B;
    localparam logic [7:0] REG_STATUS  = 8'h00;
    localparam logic [7:0] REG_FAULT   = 8'h01;
    localparam logic [7:0] REG_TSV     = 8'h02;
    localparam logic [7:0] REG_CTRL    = 8'h03;
    localparam logic [7:0] REG_TCA     = 8'h04;
    localparam logic [7:0] REG_THR0    = 8'h05;
    localparam logic [7:0] REG_THRN    = 8'h09;
    localparam logic [7:0] UNMAPPED    = 8'hFF;

    // ********************
    // field positions and reset values
    // ********************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_BIAS_BIT = 2;
    localparam int CTRL_PG_LSB   = 3;
    localparam int CTRL_HOST_BIT = 5;
    localparam int TCA_SCALE_LSB = 0;
    localparam int TCA_VREG_LSB  = 4;
    localparam logic [7:0] CTRL_RST    = 8'h24;
    localparam logic [7:0] TCA_RST     = 8'h00;
    localparam logic [7:0] TS_VOLT_RST = 8'h50;
    localparam logic [2:0] PIN_RST     = 3'h4;
    localparam logic [3:0] SCALE_FULL  = 4'h8;

    // zone bits, also threshold array index
    localparam int Z_HOT  = 0;
    localparam int Z_WARM = 1;
    localparam int Z_COOL = 2;
    localparam int Z_COLD = 3;
    localparam int Z_OPEN = 4;

    // ********************
    // thermistor thresholds, millivolts to sample code
    // ********************
    localparam int TS_FS_MV   = 1200;
    localparam int TS_HOT_MV  = 185;
    localparam int TS_WARM_MV = 265;
    localparam int TS_COOL_MV = 514;
    localparam int TS_COLD_MV = 585;
    localparam int TS_OPEN_MV = 900;
    function automatic logic [7:0] mv_to_code(input int mv);
        return 8'(mv * 256 / TS_FS_MV);
    endfunction

    // ********************
    // types
    // ********************
    typedef enum logic [1:0] {
        TS_FULL    = 2'h0,
        TS_HOTCOLD = 2'h1,
        TS_OFF     = 2'h2,
        TS_OFF2    = 2'h3
    } ts_mode_t;
    typedef enum logic [1:0] {
        PG_SUPPLY = 2'h0,
        PG_HOST   = 2'h1,
        PG_MANUAL = 2'h2,
        PG_SPARE  = 2'h3
    } pg_mode_t;
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_ADDR = 7'h02,
        S_AACK = 7'h04,
        S_WR   = 7'h08,
        S_WACK = 7'h10,
        S_RD   = 7'h20,
        S_RACK = 7'h40
    } i2c_state_t;
endpackage
`default_nettype wire
